/* File: src/pcs_sideband_ctrl.sv */
// pcie config sideband control: vf reset, l23/l3, training gate, intx
// What this block does
// R1 - raise vf bit when host starts reset
// R2 - hold vf bit until matching done
// R3 - user pulses done one cycle, after raise
// R4 - done clears bit, reopens config access
// R5 - user requests l23 only after d3, turnoff
// R6 - l23 request leads to l3 until reset
// R7 - request may be tied low; root ignores
// R8 - training enable low holds detect quiet
// R9 - four intx bits map to lines a-d
// R10 - rise asserts, fall deasserts interrupt line
// R11 - report each interrupt outcome sent or fail
// R12 - pulse sent after each intx message
// R13 - all on user clock; reset clears flags
`timescale 1ns/1ps
module pcs_sideband_ctrl import pcs_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic root_port_i,
  input wire logic [VFN_COUNT-1:0] vfn_flr_start_i,
  input wire logic [VFN_COUNT-1:0] vfn_reset_done_i,
  output logic [VFN_COUNT-1:0] vfn_reset_in_progress_o,
  output logic [VFN_COUNT-1:0] vfn_cfg_access_en_o,
  input wire logic l23_ready_request_i,
  input wire logic link_training_enable_i,
  input wire logic phy_link_up_i,
  output pcs_link_st_t link_state_o,
  output logic link_up_o,
  output logic link_in_l3_o,
  input wire logic [INTX_LINES-1:0] intx_vector_i,
  input wire logic intx_tx_ready_i,
  input wire logic intx_tx_err_i,
  output logic intx_msg_valid_o,
  output logic [INTX_IDX_W-1:0] intx_msg_line_o,
  output logic intx_msg_assert_o,
  output logic intx_sent_o,
  output logic intx_fail_o
);

  // next value of the reset-in-progress bits
  logic [VFN_COUNT-1:0] vfn_busy_next;
  // next link state
  pcs_link_st_t link_next;
  // dwell counter in l23_ready
  logic [L23_CNT_W-1:0] l23_cnt_reg;

  // vf reset flags: start wins over a done in the same cycle
  always_comb begin
    vfn_busy_next = vfn_reset_in_progress_o;
    // a done for an idle function is ignored
    vfn_busy_next = vfn_busy_next & ~vfn_reset_done_i; // R2 R3 R4
    vfn_busy_next = vfn_busy_next | vfn_flr_start_i; // R1
  end

  // vf reset flag and access enable registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vfn_reset_in_progress_o <= VFN_NONE; // R13
      vfn_cfg_access_en_o <= VFN_ALL;
    end else begin
      vfn_reset_in_progress_o <= vfn_busy_next; // R1 R2
      vfn_cfg_access_en_o <= ~vfn_busy_next; // R4
    end
  end

  // link state decisions
  always_comb begin
    link_next = link_state_o;
    case (link_state_o)
      LINK_DETECT_QUIET: begin
        // leave detect quiet only when training is enabled
        if (link_training_enable_i) begin
          link_next = LINK_TRAINING; // R8
        end
      end
      LINK_TRAINING: begin
        if (!link_training_enable_i) begin
          link_next = LINK_DETECT_QUIET; // R8
        end else if (phy_link_up_i) begin
          link_next = LINK_L0;
        end
      end
      LINK_L0: begin
        if (!link_training_enable_i || !phy_link_up_i) begin
          link_next = LINK_DETECT_QUIET; // R8
        end else if (l23_ready_request_i && !root_port_i) begin
          // request only honoured in endpoint mode
          link_next = LINK_L23_READY; // R6 R7
        end
      end
      LINK_L23_READY: begin
        // no way back; leaves only for l3, once the dwell counter ends
        if (l23_cnt_reg == L23_CNT_LAST) begin
          link_next = LINK_L3; // R6
        end
      end
      LINK_L3: begin
        link_next = LINK_L3; // R6
      end
      default: begin
        link_next = LINK_DETECT_QUIET;
      end
    endcase
  end

  // link state and its decoded flags
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_state_o <= LINK_DETECT_QUIET;
      link_up_o <= 1'b0;
      link_in_l3_o <= 1'b0;
    end else begin
      link_state_o <= link_next;
      link_up_o <= (link_next == LINK_L0);
      link_in_l3_o <= (link_next == LINK_L3);
    end
  end

  // dwell counter for the l23_ready to l3 step
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      l23_cnt_reg <= L23_CNT_ZERO;
    end else if (link_state_o == LINK_L23_READY) begin
      l23_cnt_reg <= l23_cnt_reg + L23_CNT_ONE;
    end else begin
      l23_cnt_reg <= L23_CNT_ZERO;
    end
  end

  // legacy interrupt messages, endpoint mode only
  pcs_intx_sender pcs_intx_sender_inst (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ep_mode_i(!root_port_i),
    .link_up_i(link_up_o),
    .intx_vector_i(intx_vector_i),
    .tx_ready_i(intx_tx_ready_i),
    .tx_err_i(intx_tx_err_i),
    .msg_valid_o(intx_msg_valid_o),
    .msg_line_o(intx_msg_line_o),
    .msg_assert_o(intx_msg_assert_o),
    .sent_o(intx_sent_o),
    .fail_o(intx_fail_o)
  );

  // checks on the block's own outputs

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  flr_raise_a: assert property ( // R1
    |vfn_flr_start_i |=> ((vfn_reset_in_progress_o
      & $past(vfn_flr_start_i)) == $past(vfn_flr_start_i)))
    else $error("vf reset flag not raised after start");

  flr_hold_a: assert property ( // R2
    |vfn_reset_in_progress_o |=> ((~vfn_reset_in_progress_o
      & $past(vfn_reset_in_progress_o)
      & ~$past(vfn_reset_done_i)) == VFN_NONE))
    else $error("vf reset flag dropped without done");

  flr_done_a: assert property ( // R4
    |(vfn_reset_done_i & vfn_reset_in_progress_o & ~vfn_flr_start_i)
    |=> ((vfn_cfg_access_en_o & $past(vfn_reset_done_i
      & ~vfn_flr_start_i)) == $past(vfn_reset_done_i & ~vfn_flr_start_i)))
    else $error("done did not reopen config access");

  access_match_a: assert property ( // R4
    vfn_cfg_access_en_o == ~vfn_reset_in_progress_o)
    else $error("access enable disagrees with reset flag");

  train_gate_a: assert property ( // R8
    !link_training_enable_i && (link_state_o != LINK_L23_READY)
    && (link_state_o != LINK_L3) |=> link_state_o == LINK_DETECT_QUIET)
    else $error("link left detect quiet while training disabled");

  // ten cycles in l23_ready, written as two runs of five
  l23_entry_a: assert property ( // R6
    link_state_o == LINK_L0 && link_next == LINK_L23_READY
    |=> (link_state_o == LINK_L23_READY) [*5]
    ##1 (link_state_o == LINK_L23_READY) [*5]
    ##1 link_in_l3_o)
    else $error("l23 request did not reach l3 on time");

  // dwell counter stays within its end while in l23_ready
  l23_cnt_bound_a: assert property ( // R6
    link_state_o == LINK_L23_READY |-> l23_cnt_reg <= L23_CNT_LAST)
    else $error("l23 dwell counter ran past its end");

  l3_stay_a: assert property ( // R6
    link_state_o == LINK_L3 |=> link_state_o == LINK_L3 && !link_up_o)
    else $error("link resumed after l3 without reset");

  root_ignore_a: assert property ( // R7
    root_port_i && link_state_o == LINK_L0
    |=> link_state_o != LINK_L23_READY)
    else $error("root port honoured l23 request");

  intx_sent_a: assert property ( // R12
    intx_msg_valid_o && intx_tx_ready_i
    |=> intx_sent_o && !intx_msg_valid_o ##1 !intx_sent_o)
    else $error("sent pulse missing after message");

  intx_fail_a: assert property ( // R11
    intx_msg_valid_o && !intx_tx_ready_i && intx_tx_err_i
    |=> intx_fail_o && !intx_sent_o)
    else $error("fail pulse missing after refused message");

  // a pending message keeps its line and kind until answered
  intx_hold_a: assert property ( // R10
    intx_msg_valid_o && !intx_tx_ready_i && !intx_tx_err_i
    |=> intx_msg_valid_o && $stable(intx_msg_line_o)
      && $stable(intx_msg_assert_o))
    else $error("message changed before it was taken");

  flr_cycle_c: cover property (
    $rose(vfn_reset_in_progress_o[0]) ##[1:20]
    $fell(vfn_reset_in_progress_o[0]));
  l3_reach_c: cover property ($rose(link_in_l3_o));
  // refused or linkless interrupt change
  intx_fail_c: cover property ($rose(intx_fail_o));
  intx_pair_c: cover property (
    intx_sent_o && intx_msg_assert_o ##[1:50]
    intx_sent_o && !intx_msg_assert_o);

endmodule

/* File: src/pcs_pkg.sv */
// shared constants and types for the pcie config sideband control block
package pcs_pkg;

  // number of virtual functions with a reset handshake
  localparam int VFN_COUNT = 6;
  // number of legacy interrupt lines (A, B, C, D)
  localparam int INTX_LINES = 4;
  // width of the interrupt line index
  localparam int INTX_IDX_W = 2;

  // reset value of the per-function reset-in-progress bits
  localparam logic [VFN_COUNT-1:0] VFN_NONE = 6'h00;
  // reset value of the per-function access-enable bits
  localparam logic [VFN_COUNT-1:0] VFN_ALL = 6'h3F;
  // reset value of the reported interrupt line levels
  localparam logic [INTX_LINES-1:0] INTX_NONE = 4'h0;
  // reset value of the interrupt line index
  localparam logic [INTX_IDX_W-1:0] INTX_IDX_ZERO = 2'h0;

  // user clock period in nanoseconds
  localparam int CLK_PERIOD_NS = 10;
  // least time spent in l23_ready before the link is taken to l3
  localparam int L23_ENTRY_NS = 100;
  // the same least time in clock cycles, rounded up
  localparam int L23_ENTRY_CYC =
    (L23_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // width of the l23 dwell counter
  localparam int L23_CNT_W = 8;
  // terminal value of the l23 dwell counter
  localparam logic [L23_CNT_W-1:0] L23_CNT_LAST =
    L23_CNT_W'(L23_ENTRY_CYC - 1);
  // reset value of the l23 dwell counter
  localparam logic [L23_CNT_W-1:0] L23_CNT_ZERO = 8'h00;
  // counter step
  localparam logic [L23_CNT_W-1:0] L23_CNT_ONE = 8'h01;

  // link state as seen by the sideband logic
  typedef enum logic [2:0] {
    LINK_DETECT_QUIET,
    LINK_TRAINING,
    LINK_L0,
    LINK_L23_READY,
    LINK_L3
  } pcs_link_st_t;

  // legacy interrupt message sender state
  typedef enum logic {
    INTX_IDLE,
    INTX_WAIT
  } pcs_intx_st_t;

endpackage

/* File: src/pcs_intx_sender.sv */
// legacy interrupt assert/deassert message sender with sent/fail status
`timescale 1ns/1ps
module pcs_intx_sender import pcs_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ep_mode_i,
  input wire logic link_up_i,
  input wire logic [INTX_LINES-1:0] intx_vector_i,
  input wire logic tx_ready_i,
  input wire logic tx_err_i,
  output logic msg_valid_o,
  output logic [INTX_IDX_W-1:0] msg_line_o,
  output logic msg_assert_o,
  output logic sent_o,
  output logic fail_o
);

  // state of the message handshake
  pcs_intx_st_t state_reg;
  // line levels already reported to the root complex
  logic [INTX_LINES-1:0] seen_reg;
  // lines whose level differs from the reported one
  logic [INTX_LINES-1:0] pend;
  // lowest pending line
  logic [INTX_IDX_W-1:0] pick;

  // find changed lines, lowest index first
  always_comb begin
    pend = intx_vector_i ^ seen_reg;
    pick = INTX_IDX_ZERO;
    for (int i = INTX_LINES - 1; i >= 0; i--) begin
      if (pend[i]) begin
        pick = INTX_IDX_W'(i);
      end
    end
  end

  // one message at a time; outcome reported as sent or fail pulse
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= INTX_IDLE;
      seen_reg <= INTX_NONE;
      msg_valid_o <= 1'b0;
      msg_line_o <= INTX_IDX_ZERO;
      msg_assert_o <= 1'b0;
      sent_o <= 1'b0;
      fail_o <= 1'b0;
    end else begin
      sent_o <= 1'b0;
      fail_o <= 1'b0;
      case (state_reg)
        INTX_IDLE: begin
          if (!ep_mode_i) begin
            // root port: vector unused, track it silently
            seen_reg <= intx_vector_i;
          end else if (|pend) begin
            if (!link_up_i) begin
              // no link to carry the message
              fail_o <= 1'b1; // R11
              seen_reg[pick] <= intx_vector_i[pick];
            end else begin
              // bit i maps to line A..D; rise asserts, fall deasserts
              msg_valid_o <= 1'b1; // R9 R10
              msg_line_o <= pick;
              msg_assert_o <= intx_vector_i[pick];
              state_reg <= INTX_WAIT;
            end
          end
        end
        INTX_WAIT: begin
          if (tx_ready_i) begin
            // message taken by the transmit path
            msg_valid_o <= 1'b0;
            sent_o <= 1'b1; // R12
            seen_reg[msg_line_o] <= msg_assert_o;
            state_reg <= INTX_IDLE;
          end else if (tx_err_i) begin
            // transmit path refused the message
            msg_valid_o <= 1'b0;
            fail_o <= 1'b1; // R11
            seen_reg[msg_line_o] <= msg_assert_o;
            state_reg <= INTX_IDLE;
          end
        end
        default: begin
          state_reg <= INTX_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: verification/pcs_user_model.sv */
// user application model: vf reset-done replies and intx transmit path
`timescale 1ns/1ps
module pcs_user_model import pcs_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [3:0] dly_i,
  input wire logic err_mode_i,
  input wire logic [VFN_COUNT-1:0] busy_i,
  input wire logic msg_valid_i,
  output logic [VFN_COUNT-1:0] done_o,
  output logic tx_ready_o,
  output logic tx_err_o
);
  logic [3:0] vcnt_reg; // cycles waited before a done pulse
  logic [3:0] tcnt_reg; // cycles waited before taking a message
  // one-cycle done for the lowest busy vf, only once it is seen busy
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vcnt_reg <= 4'h0;
      done_o <= VFN_NONE;
    end else begin
      done_o <= VFN_NONE;
      if (busy_i != VFN_NONE && done_o == VFN_NONE) begin
        vcnt_reg <= vcnt_reg + 4'h1;
        if (vcnt_reg == dly_i) begin
          vcnt_reg <= 4'h0;
          done_o <= busy_i & (~busy_i + 6'h01);
        end
      end
    end
  end
  // take or refuse a pending message after the set delay
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tcnt_reg <= 4'h0;
      tx_ready_o <= 1'b0;
      tx_err_o <= 1'b0;
    end else begin
      tx_ready_o <= 1'b0;
      tx_err_o <= 1'b0;
      if (msg_valid_i && !tx_ready_o && !tx_err_o) begin
        tcnt_reg <= tcnt_reg + 4'h1;
        if (tcnt_reg == dly_i) begin
          tcnt_reg <= 4'h0;
          tx_ready_o <= !err_mode_i;
          tx_err_o <= err_mode_i;
        end
      end
    end
  end
endmodule

/* File: verification/pcs_sideband_ctrl_tb.sv */
// self-checking bench for the pcie config sideband control block
`timescale 1ns/1ps
module pcs_sideband_ctrl_tb import pcs_pkg::*; ;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic root = 1'b0;
  logic l23 = 1'b0;
  logic ten = 1'b0;
  logic phy = 1'b0;
  logic emode = 1'b0;
  logic [VFN_COUNT-1:0] start = VFN_NONE;
  logic [INTX_LINES-1:0] vec = INTX_NONE;
  logic [VFN_COUNT-1:0] done, busy, acc;
  pcs_link_st_t st;
  logic lup, l3, rdy, err, mv, mas, sent, fail;
  logic [INTX_IDX_W-1:0] mln;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  always #5 clock_i = ~clock_i;
  pcs_sideband_ctrl pcs_sideband_ctrl_inst (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .root_port_i(root), .vfn_flr_start_i(start),
    .vfn_reset_done_i(done), .vfn_reset_in_progress_o(busy),
    .vfn_cfg_access_en_o(acc), .l23_ready_request_i(l23),
    .link_training_enable_i(ten), .phy_link_up_i(phy),
    .link_state_o(st), .link_up_o(lup), .link_in_l3_o(l3),
    .intx_vector_i(vec), .intx_tx_ready_i(rdy), .intx_tx_err_i(err),
    .intx_msg_valid_o(mv), .intx_msg_line_o(mln),
    .intx_msg_assert_o(mas), .intx_sent_o(sent), .intx_fail_o(fail));
  pcs_user_model pcs_user_model_inst (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .dly_i(4'h2), .err_mode_i(emode), .busy_i(busy),
    .msg_valid_i(mv), .done_o(done), .tx_ready_o(rdy), .tx_err_o(err));
  // compare one value and report a mismatch
  task automatic chk(input string w, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask
  // pass n rising edges, then let their updates land
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // change one intx line and follow the message and its status
  task automatic intx(input int ln, input logic lv, input logic msg,
                      input logic ok);
    int k;
    logic seen;
    seen = 1'b0;
    k = 0;
    @(posedge clock_i);
    vec[ln] <= lv;
    #1;
    while (sent !== 1'b1 && fail !== 1'b1 && k < 40) begin
      step(1);
      k++;
      if (mv === 1'b1 && !seen) begin
        seen = 1'b1;
        chk("msg_line", 8'(ln), 8'(mln));
        chk("msg_assert", 8'(lv), 8'(mas));
      end
    end
    chk("msg_seen", 8'(msg), 8'(seen));
    chk("sent", 8'(ok), 8'(sent));
    chk("fail", 8'(!ok), 8'(fail));
    step(1);
    chk("pulse_end", 8'h00, 8'({sent, fail}));
  endtask
  // counts, verdict, end of run
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    step(1);
    chk("busy_rst", 8'(VFN_NONE), 8'(busy));
    chk("acc_rst", 8'(VFN_ALL), 8'(acc));
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    // each vf raised, held, then cleared by its done pulse
    for (int i = 0; i < VFN_COUNT; i++) begin
      @(posedge clock_i);
      start[i] <= 1'b1;
      @(posedge clock_i);
      start[i] <= 1'b0;
      #1;
      chk("busy_set", 8'(6'h01 << i), 8'(busy));
      chk("acc_off", 8'(VFN_ALL ^ (6'h01 << i)), 8'(acc));
      step(2);
      chk("busy_hold", 8'(6'h01 << i), 8'(busy));
      step(3);
      chk("busy_clr", 8'(VFN_NONE), 8'(busy));
      chk("acc_on", 8'(VFN_ALL), 8'(acc));
    end
    // no link yet: change is refused with a fail pulse
    phy <= 1'b1;
    intx(0, 1'b1, 1'b0, 1'b0);
    step(3);
    chk("gate_low", 8'(LINK_DETECT_QUIET), 8'(st));
    @(posedge clock_i);
    ten <= 1'b1;
    step(1);
    chk("training", 8'(LINK_TRAINING), 8'(st));
    step(1);
    chk("link_up", 8'h01, 8'(lup));
    intx(0, 1'b0, 1'b1, 1'b1);
    for (int j = 0; j < INTX_LINES; j++) begin
      intx(j, 1'b1, 1'b1, 1'b1);
      intx(j, 1'b0, 1'b1, 1'b1);
    end
    emode <= 1'b1;
    intx(2, 1'b1, 1'b1, 1'b0);
    emode <= 1'b0;
    intx(2, 1'b0, 1'b1, 1'b1);
    // root mode: no messages, no l23 entry
    root <= 1'b1;
    vec[3] <= 1'b1;
    l23 <= 1'b1;
    step(5);
    chk("root_quiet", 8'h00, 8'({mv, sent, fail}));
    chk("root_l23", 8'(LINK_L0), 8'(st));
    @(posedge clock_i);
    root <= 1'b0;
    vec[3] <= 1'b0;
    step(1);
    chk("l23_enter", 8'(LINK_L23_READY), 8'(st));
    step(9);
    chk("l23_dwell", 8'(LINK_L23_READY), 8'(st));
    step(1);
    chk("l3", 8'h01, 8'(l3));
    @(posedge clock_i);
    ten <= 1'b0;
    l23 <= 1'b0;
    step(5);
    chk("l3_stays", 8'(LINK_L3), 8'(st));
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    step(1);
    chk("l3_reset", 8'(LINK_DETECT_QUIET), 8'(st));
    print_verdict();
  end
endmodule
